// ===== logic/pmc_top.sv
// Power mode sequencer, peripheral clock gating and system clock control
//
// Functional notes
// - Normal mode clocks core and gated-on peripherals
// - Idle bit halts core; any interrupt resumes
// - Suspend stops all clocks; USB activity resumes
// - Stop bit cuts power; any reset exits
// - Shutdown keeps 5V regulator; pin/POR exit
// - Reset clock is fast oscillator /4 /8
// - Divider offers ratios 1, 2, 4, 8
// - Source is fast, slow or external clock
// - Unused peripheral clocks are gated off
// - Leaving reset restarts program at 0x0000
`timescale 1ns/100ps
module pmc_top (
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       irq_pending,
	input  wire logic       usb_activity,
	input  wire logic       ext_reset_pin_n,
	input  wire logic       por_event,
	input  wire logic       other_reset,
	output logic            core_clk_en,
	output logic      [7:0] periph_clk_en,
	output logic            power_nets_on,
	output logic            reg5v_on,
	output logic            pin_hold,
	output logic            core_reset,
	output logic            pc_restart,
	output logic     [15:0] pc_start_addr,
	output logic      [1:0] system_clock_src,
	output logic      [5:0] system_clock_ratio,
	output logic            sys_tick
);

	// ****************************************
	// Declarations
	// ****************************************
	pmc_pkg::pmc_mode_t state;
	pmc_pkg::pmc_mode_t next_state;
	logic [7:0] power_control_reg;
	logic [7:0] fast_osc_control_reg;
	logic [7:0] regulator_control_reg;
	logic [7:0] clk_sel;
	logic [7:0] periph_gate;
	logic       usb_s1, usb_s2;
	logic       pin_s1, pin_s2;
	logic       pin_rst;
	logic       rst_wake;
	logic       wr_ok;
	logic       idle_exit;
	logic       susp_exit;

	// ****************************************
	// Pin synchronisers and wake decode
	// ****************************************

	// Two flops on each pin input
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			usb_s1 <= 1'b0;
			usb_s2 <= 1'b0;
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
		end
		else
		begin
			usb_s1 <= usb_activity;
			usb_s2 <= usb_s1;
			pin_s1 <= ext_reset_pin_n;
			pin_s2 <= pin_s1;
		end
	end

	// Shutdown listens only to the pin and power-on reset
	assign pin_rst  = !pin_s2;
	assign rst_wake = (state == pmc_pkg::PMC_SHUTDOWN) ? (por_event || pin_rst)
	                : (por_event || pin_rst || other_reset);

	assign idle_exit = (state == pmc_pkg::PMC_IDLE) && irq_pending && !rst_wake;
	assign susp_exit = (state == pmc_pkg::PMC_SUSPEND) && usb_s2 && !rst_wake;
	assign wr_ok     = reg_wr && (state != pmc_pkg::PMC_RESET);

	// ****************************************
	// Mode sequencer
	// ****************************************

	// Next mode from requests, wake events and resets
	always_comb
	begin
		next_state = state;
		unique case (state)
			pmc_pkg::PMC_NORMAL:
			begin
				if (rst_wake)
					next_state = pmc_pkg::PMC_RESET;
				else if (power_control_reg[pmc_pkg::PWR_STOP_BIT])
					next_state = regulator_control_reg[pmc_pkg::REGL_DEEP_BIT]
					           ? pmc_pkg::PMC_SHUTDOWN : pmc_pkg::PMC_STOP;
				else if (power_control_reg[pmc_pkg::PWR_IDLE_BIT])
					next_state = pmc_pkg::PMC_IDLE;
				else if (fast_osc_control_reg[pmc_pkg::FOSC_SUSP_BIT])
					next_state = pmc_pkg::PMC_SUSPEND;
			end
			pmc_pkg::PMC_IDLE:
			begin
				if (rst_wake)
					next_state = pmc_pkg::PMC_RESET;
				else if (irq_pending)
					next_state = pmc_pkg::PMC_NORMAL;
			end
			pmc_pkg::PMC_SUSPEND:
			begin
				if (rst_wake)
					next_state = pmc_pkg::PMC_RESET;
				else if (usb_s2)
					next_state = pmc_pkg::PMC_NORMAL;
			end
			pmc_pkg::PMC_STOP, pmc_pkg::PMC_SHUTDOWN:
			begin
				if (rst_wake)
					next_state = pmc_pkg::PMC_RESET;
			end
			pmc_pkg::PMC_RESET:
			begin
				if (!rst_wake)
					next_state = pmc_pkg::PMC_NORMAL;
			end
			default:
				next_state = pmc_pkg::PMC_RESET;
		endcase
	end

	// Mode register
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			state <= pmc_pkg::PMC_RESET;
		else
			state <= next_state;
	end

	// ****************************************
	// Registers
	// ****************************************

	// Power control: idle clears on wake, stop clears through reset
	always_ff @(posedge clk_sys)
	begin
		if (srst || state == pmc_pkg::PMC_RESET)
			power_control_reg <= pmc_pkg::PWR_RST;
		else if (wr_ok && reg_addr == pmc_pkg::OFS_PWR_CTRL)
			power_control_reg <= reg_wdata & pmc_pkg::PWR_MASK;
		else if (idle_exit)
			power_control_reg[pmc_pkg::PWR_IDLE_BIT] <= 1'b0;
	end

	// Fast oscillator control: suspend clears on wake
	always_ff @(posedge clk_sys)
	begin
		if (srst || state == pmc_pkg::PMC_RESET)
			fast_osc_control_reg <= pmc_pkg::FOSC_RST;
		else if (wr_ok && reg_addr == pmc_pkg::OFS_FOSC_CTRL)
			fast_osc_control_reg <= reg_wdata & pmc_pkg::FOSC_MASK;
		else if (susp_exit)
			fast_osc_control_reg[pmc_pkg::FOSC_SUSP_BIT] <= 1'b0;
	end

	// Regulator, clock select and peripheral gate registers
	always_ff @(posedge clk_sys)
	begin
		if (srst || state == pmc_pkg::PMC_RESET)
		begin
			regulator_control_reg <= pmc_pkg::REGL_RST;
			clk_sel               <= pmc_pkg::CLK_RST;
			periph_gate           <= pmc_pkg::PERIPH_RST;
		end
		else if (wr_ok)
		begin
			if (reg_addr == pmc_pkg::OFS_REGL_CTRL)
				regulator_control_reg <= reg_wdata & pmc_pkg::REGL_MASK;
			if (reg_addr == pmc_pkg::OFS_CLK_SEL)
				clk_sel <= reg_wdata & pmc_pkg::CLK_MASK;
			if (reg_addr == pmc_pkg::OFS_PERIPH_EN)
				periph_gate <= reg_wdata;
		end
	end

	// Read data stand in the cycle after the strobe only
	always_ff @(posedge clk_sys)
	begin
		if (srst || !reg_rd)
			reg_rdata <= 8'h00;
		else
		begin
			unique case (reg_addr)
				pmc_pkg::OFS_PWR_CTRL:  reg_rdata <= power_control_reg;
				pmc_pkg::OFS_FOSC_CTRL: reg_rdata <= fast_osc_control_reg;
				pmc_pkg::OFS_REGL_CTRL: reg_rdata <= regulator_control_reg;
				pmc_pkg::OFS_CLK_SEL:   reg_rdata <= clk_sel;
				pmc_pkg::OFS_PERIPH_EN: reg_rdata <= periph_gate;
				pmc_pkg::OFS_STATUS:    reg_rdata <= {5'h00, state};
				default:                reg_rdata <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// Clock, power and pin controls
	// ****************************************

	// Core runs only in Normal; peripherals also in Idle, per gate
	assign core_clk_en   = (state == pmc_pkg::PMC_NORMAL);
	assign periph_clk_en = (state == pmc_pkg::PMC_NORMAL || state == pmc_pkg::PMC_IDLE)
	                     ? periph_gate : 8'h00;
	assign pin_hold      = (state == pmc_pkg::PMC_STOP || state == pmc_pkg::PMC_SHUTDOWN);
	assign power_nets_on = !pin_hold;
	assign reg5v_on      = regulator_control_reg[pmc_pkg::REGL_5V_BIT];
	assign core_reset    = (state == pmc_pkg::PMC_RESET);
	assign pc_restart    = core_reset && !rst_wake;
	assign pc_start_addr = pmc_pkg::PC_START;

	// Source and divider; no ticks while high-frequency clocks stop
	pmc_clk_sel u_clk_sel (
		.clk_sys      (clk_sys),
		.srst         (srst),
		.run          (core_clk_en || state == pmc_pkg::PMC_IDLE),
		.src_sel      (clk_sel[pmc_pkg::CLK_SRC_LSB +: 2]),
		.pdiv_en      (fast_osc_control_reg[pmc_pkg::FOSC_PDIV_BIT]),
		.div_sel      (clk_sel[pmc_pkg::CLK_DIV_LSB +: 2]),
		.system_clock_src   (system_clock_src),
		.system_clock_ratio (system_clock_ratio),
		.sys_tick     (sys_tick)
	);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	sequence s_reset_release;
		core_reset && !por_event && !other_reset && pin_s2;
	endsequence

	sequence s_back_in_normal;
		state == pmc_pkg::PMC_NORMAL && core_clk_en;
	endsequence

	a_normal_clocks: assert property (
		state == pmc_pkg::PMC_NORMAL |-> core_clk_en && periph_clk_en == periph_gate)
		else $error("normal mode clocks missing");

	a_idle_wake_irq: assert property (
		state == pmc_pkg::PMC_IDLE && irq_pending && !rst_wake
		|=> s_back_in_normal and !power_control_reg[pmc_pkg::PWR_IDLE_BIT])
		else $error("idle did not resume on interrupt");

	a_suspend_halt: assert property (
		state == pmc_pkg::PMC_SUSPEND |-> !core_clk_en && periph_clk_en == 8'h00)
		else $error("clocks running in suspend");

	a_usb_wake: assert property (
		$rose(usb_activity) && state == pmc_pkg::PMC_SUSPEND
		&& !rst_wake
		##1 (state == pmc_pkg::PMC_SUSPEND && !rst_wake)
		##1 (state == pmc_pkg::PMC_SUSPEND && !rst_wake)
		|=> s_back_in_normal)
		else $error("usb activity did not end suspend");

	a_stop_any_reset: assert property (
		state == pmc_pkg::PMC_STOP && other_reset
		|=> core_reset ##1 !power_control_reg[pmc_pkg::PWR_STOP_BIT])
		else $error("stop not left on reset source");

	a_shutdown_hold: assert property (
		state == pmc_pkg::PMC_SHUTDOWN && !por_event && !pin_rst
		|=> state == pmc_pkg::PMC_SHUTDOWN && pin_hold && !power_nets_on)
		else $error("shutdown left without pin or power-on reset");

	a_reset_clock: assert property (
		core_reset ##1 !core_reset
		|=> system_clock_src == pmc_pkg::SRC_FAST && system_clock_ratio == pmc_pkg::RATIO_RST)
		else $error("clock after reset not fast oscillator divided by 32");

	a_src_follow: assert property (
		wr_ok && reg_addr == pmc_pkg::OFS_CLK_SEL |-> ##2 system_clock_src == $past(reg_wdata[1:0], 2))
		else $error("clock source did not follow write");

	a_gate_off: assert property (
		(periph_clk_en & ~periph_gate) == 8'h00)
		else $error("gated peripheral still clocked");

	a_pc_restart: assert property (
		s_reset_release |-> pc_restart && pc_start_addr == 16'h0000 ##1 s_back_in_normal)
		else $error("program restart missing after reset");

endmodule

// ===== logic/pmc_pkg.sv
// Constants, types and helpers shared by the power mode and clock controller
package pmc_pkg;

	// ****************************************
	// Register bus
	// ****************************************
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	localparam logic [2:0] OFS_PWR_CTRL  = 3'h0;   // power_control_reg
	localparam logic [2:0] OFS_FOSC_CTRL = 3'h1;   // fast_osc_control_reg
	localparam logic [2:0] OFS_REGL_CTRL = 3'h2;   // regulator_control_reg
	localparam logic [2:0] OFS_CLK_SEL   = 3'h3;   // clock source and divider
	localparam logic [2:0] OFS_PERIPH_EN = 3'h4;   // peripheral clock gates
	localparam logic [2:0] OFS_STATUS    = 3'h5;   // current mode, read only

	// Field positions
	localparam int PWR_IDLE_BIT  = 0;
	localparam int PWR_STOP_BIT  = 1;
	localparam int FOSC_SUSP_BIT = 0;
	localparam int FOSC_PDIV_BIT = 1;
	localparam int REGL_DEEP_BIT = 0;
	localparam int REGL_5V_BIT   = 1;
	localparam int CLK_SRC_LSB   = 0;
	localparam int CLK_DIV_LSB   = 4;

	// Writable bits of each register
	localparam logic [7:0] PWR_MASK  = 8'h03;
	localparam logic [7:0] FOSC_MASK = 8'h03;
	localparam logic [7:0] REGL_MASK = 8'h03;
	localparam logic [7:0] CLK_MASK  = 8'h33;

	// Values after reset: fast oscillator, divide by 4 then by 8
	localparam logic [7:0] PWR_RST    = 8'h00;
	localparam logic [7:0] FOSC_RST   = 8'h02;
	localparam logic [7:0] REGL_RST   = 8'h00;
	localparam logic [7:0] CLK_RST    = 8'h30;
	localparam logic [7:0] PERIPH_RST = 8'hFF;
	localparam logic [5:0] RATIO_RST  = 6'h20;

	// Clock sources and dividers
	localparam logic [1:0] SRC_FAST = 2'h0;        // fast_internal_osc, 48 MHz
	localparam logic [1:0] SRC_SLOW = 2'h1;        // slow_internal_osc, 80 kHz
	localparam logic [1:0] SRC_EXT  = 2'h2;        // external_clock_input
	localparam int FAST_OSC_KHZ = 48000;
	localparam int SLOW_OSC_KHZ = 80;
	localparam int PRE_DIV      = 4;

	// First address executed after any reset
	localparam logic [15:0] PC_START = 16'h0000;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		PMC_NORMAL   = 3'b000,
		PMC_IDLE     = 3'b001,
		PMC_SUSPEND  = 3'b010,
		PMC_STOP     = 3'b011,
		PMC_SHUTDOWN = 3'b100,
		PMC_RESET    = 3'b101
	} pmc_mode_t;

	// Total division from oscillator to system clock: prescale, then 1/2/4/8
	function automatic logic [5:0] div_ratio(input logic pdiv, input logic [1:0] sel);
		logic [5:0] base;
		base = pdiv ? 6'(PRE_DIV) : 6'h01;
		return 6'(base << sel);
	endfunction

endpackage

// ===== logic/pmc_clk_sel.sv
// System clock source selection and divider tick generator
`timescale 1ns/100ps
module pmc_clk_sel (
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       run,
	input  wire logic [1:0] src_sel,
	input  wire logic       pdiv_en,
	input  wire logic [1:0] div_sel,
	output logic      [1:0] system_clock_src,
	output logic      [5:0] system_clock_ratio,
	output logic            sys_tick
);

	logic [5:0] cnt;

	// Registered source and total ratio
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			system_clock_src   <= pmc_pkg::SRC_FAST;
			system_clock_ratio <= pmc_pkg::RATIO_RST;
		end
		else
		begin
			system_clock_src   <= src_sel;
			system_clock_ratio <= pmc_pkg::div_ratio(pdiv_en, div_sel);
		end
	end

	// One tick per divided period; stops while clocks are halted
	always_ff @(posedge clk_sys)
	begin
		if (srst || !run)
		begin
			cnt      <= 6'h00;
			sys_tick <= 1'b0;
		end
		else if (cnt >= system_clock_ratio - 6'h01)
		begin
			cnt      <= 6'h00;
			sys_tick <= 1'b1;
		end
		else
		begin
			cnt      <= cnt + 6'h01;
			sys_tick <= 1'b0;
		end
	end

endmodule

// ===== testbench/pmc_core_model.sv
// Processor core and wake source model driving the power controller
`timescale 1ns/100ps
module pmc_core_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] reg_rdata,
	output logic      [2:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic            irq_pending,
	output logic            usb_activity,
	output logic            ext_reset_pin_n,
	output logic            por_event,
	output logic            other_reset
);
	// Idle bus and quiet wake sources from time zero
	initial
	begin
		reg_addr        = 3'h0;
		reg_wdata       = 8'h00;
		reg_wr          = 1'b0;
		reg_rd          = 1'b0;
		irq_pending     = 1'b0;
		usb_activity    = 1'b0;
		ext_reset_pin_n = 1'b1;
		por_event       = 1'b0;
		other_reset     = 1'b0;
	end

	// One-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// One-cycle read strobe, data taken in the cycle after
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Wake and reset sources as {irq, usb, pin_n, por, other}
	task automatic wake(input logic [4:0] v);
		@(posedge clk_sys);
		irq_pending     <= v[4];
		usb_activity    <= v[3];
		ext_reset_pin_n <= v[2];
		por_event       <= v[1];
		other_reset     <= v[0];
	endtask

	// Fast oscillator selected before the suspend bit
	task automatic enter_suspend();
		wr(pmc_pkg::OFS_CLK_SEL, 8'h30);
		wr(pmc_pkg::OFS_FOSC_CTRL, 8'h03);
	endtask

	// Deep-off bit and 5V enable set before the stop bit
	task automatic enter_shutdown();
		wr(pmc_pkg::OFS_REGL_CTRL, 8'h03);
		wr(pmc_pkg::OFS_PWR_CTRL, 8'h02);
	endtask
endmodule

// ===== testbench/power_mode_clock_control_tb_top.sv
// Self-checking testbench for the power mode and clock controller
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
	begin \
		checks_done++; \
		if ((got) !== (ex)) \
		begin \
			miscompares++; \
			$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
		end \
	end
module power_mode_clock_control_tb_top;
	logic        clk_sys;
	logic        srst;
	logic [2:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        irq_pending;
	logic        usb_activity;
	logic        ext_reset_pin_n;
	logic        por_event;
	logic        other_reset;
	logic        core_clk_en;
	logic [7:0]  periph_clk_en;
	logic        power_nets_on;
	logic        reg5v_on;
	logic        pin_hold;
	logic        core_reset;
	logic        pc_restart;
	logic [15:0] pc_start_addr;
	logic [1:0]  system_clock_src;
	logic [5:0]  system_clock_ratio;
	logic        sys_tick;
	logic [7:0]  rv;
	int          miscompares = 0;
	int          checks_done = 0;
	int          restarts = 0;
	int          ticks = 0;
	logic [7:0]  rst_tbl [7] = '{8'h00, 8'h02, 8'h00, 8'h30, 8'hFF, 8'h00, 8'h00};

	pmc_top dut (
		.clk_sys         (clk_sys),
		.srst            (srst),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_wr          (reg_wr),
		.reg_rd          (reg_rd),
		.reg_rdata       (reg_rdata),
		.irq_pending     (irq_pending),
		.usb_activity    (usb_activity),
		.ext_reset_pin_n (ext_reset_pin_n),
		.por_event       (por_event),
		.other_reset     (other_reset),
		.core_clk_en     (core_clk_en),
		.periph_clk_en   (periph_clk_en),
		.power_nets_on   (power_nets_on),
		.reg5v_on        (reg5v_on),
		.pin_hold        (pin_hold),
		.core_reset      (core_reset),
		.pc_restart      (pc_restart),
		.pc_start_addr   (pc_start_addr),
		.system_clock_src      (system_clock_src),
		.system_clock_ratio    (system_clock_ratio),
		.sys_tick        (sys_tick)
	);

	pmc_core_model core (
		.clk_sys         (clk_sys),
		.reg_rdata       (reg_rdata),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_wr          (reg_wr),
		.reg_rd          (reg_rd),
		.irq_pending     (irq_pending),
		.usb_activity    (usb_activity),
		.ext_reset_pin_n (ext_reset_pin_n),
		.por_event       (por_event),
		.other_reset     (other_reset)
	);

	// 50 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Count restart pulses and divider ticks
	always @(posedge clk_sys)
	begin
		if (pc_restart === 1'b1 && srst === 1'b0) restarts++;
		if (sys_tick === 1'b1) ticks++;
	end

	task automatic wrap_up();
		$display("checks_done %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Bounded wait for the core clock to run again
	task automatic wait_run();
		for (int i = 0; i < 40 && core_clk_en !== 1'b1; i++) tick(1);
		if (core_clk_en !== 1'b1)
		begin
			miscompares++;
			$display("CHECK FAILED core_clk_en expected 1 seen %b", core_clk_en);
			wrap_up();
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		`CHK("restart", 1, restarts)
		`CHK("pc_start", 16'h0000, pc_start_addr)
		`CHK("src", pmc_pkg::SRC_FAST, system_clock_src)
		`CHK("ratio", 6'h20, system_clock_ratio)
		`CHK("core_en", 1'b1, core_clk_en)
		`CHK("periph", 8'hFF, periph_clk_en)
		ticks = 0;
		tick(65);
		`CHK("ticks", 2, ticks)
		core.wr(3'h6, 8'hAA);
		core.wr(pmc_pkg::OFS_STATUS, 8'h03);
		for (int a = 0; a < 7; a++)
		begin
			core.rd(3'(a), rv);
			`CHK("reset_reg", rst_tbl[a], rv)
		end
	endtask

	task automatic t_idle();
		core.wr(pmc_pkg::OFS_PWR_CTRL, 8'h01);
		tick(2);
		`CHK("idle_core", 1'b0, core_clk_en)
		`CHK("idle_periph", 8'hFF, periph_clk_en)
		core.wake(5'b10100);
		wait_run();
		core.wake(5'b00100);
		core.rd(pmc_pkg::OFS_PWR_CTRL, rv);
		`CHK("idle_bit", 8'h00, rv)
	endtask

	task automatic t_clock();
		for (int s = 0; s < 4; s++)
		begin
			core.wr(pmc_pkg::OFS_CLK_SEL, {2'b00, 2'(s), 2'b00, 2'(s % 3)});
			tick(3);
			`CHK("ratio", 6'(4 << s), system_clock_ratio)
			`CHK("src", 2'(s % 3), system_clock_src)
		end
		core.wr(pmc_pkg::OFS_FOSC_CTRL, 8'h00);
		tick(3);
		`CHK("ratio_nopre", 6'h08, system_clock_ratio)
		core.wr(pmc_pkg::OFS_PERIPH_EN, 8'h05);
		tick(2);
		`CHK("gate", 8'h05, periph_clk_en)
	endtask

	task automatic t_suspend();
		core.enter_suspend();
		tick(2);
		core.wake(5'b10100);
		tick(4);
		`CHK("susp_core", 1'b0, core_clk_en)
		`CHK("susp_periph", 8'h00, periph_clk_en)
		core.wake(5'b01100);
		wait_run();
		core.wake(5'b00100);
		core.rd(pmc_pkg::OFS_FOSC_CTRL, rv);
		`CHK("susp_bit", 1'b0, rv[0])
	endtask

	task automatic t_stop();
		int r0;
		r0 = restarts;
		core.wr(pmc_pkg::OFS_PWR_CTRL, 8'h02);
		tick(2);
		core.wake(5'b10100);
		tick(4);
		`CHK("stop_nets", 1'b0, power_nets_on)
		`CHK("stop_hold", 1'b1, pin_hold)
		`CHK("stop_core", 1'b0, core_clk_en)
		core.wake(5'b00101);
		core.wake(5'b00100);
		wait_run();
		`CHK("stop_restart", r0 + 1, restarts)
		core.rd(pmc_pkg::OFS_PWR_CTRL, rv);
		`CHK("stop_bit", 8'h00, rv)
	endtask

	task automatic t_shutdown();
		core.enter_shutdown();
		tick(2);
		core.wake(5'b00101);
		core.wake(5'b00100);
		tick(4);
		`CHK("sd_5v", 1'b1, reg5v_on)
		`CHK("sd_nets", 1'b0, power_nets_on)
		`CHK("sd_hold", 1'b1, pin_hold)
		core.wake(5'b00000);
		tick(4);
		`CHK("sd_in_reset", 1'b1, core_reset)
		core.wake(5'b00100);
		wait_run();
		`CHK("sd_5v_off", 1'b0, reg5v_on)
	endtask

	// Reset, then every scenario in turn
	initial
	begin
		srst = 1'b1;
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		wait_run();
		t_reset();
		t_idle();
		t_clock();
		t_suspend();
		t_stop();
		t_shutdown();
		wrap_up();
	end
endmodule
